// *** hw/ccs_pkg.sv ***
// constants shared by the cpu clock select and divider block
package ccs_pkg;
	localparam logic [7:0] PCC_RESET = 8'h00;
	localparam int HS_STOP_BIT = 7;
	localparam int FB_RES_OFF_BIT = 6;
	localparam int ON_SUB_BIT = 5;
	localparam int SUB_SEL_BIT = 4;
	localparam int ZERO_BIT = 3;
	localparam int DIV_MSB = 2;
	localparam int DIV_WIDTH = 3;
	localparam logic [2:0] DIV_MAX_CODE = 3'h4;
	localparam logic [2:0] SUB_DIV_CODE = 3'h1;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic APP_SUB_RESET = 1'b0;
	localparam logic APP_MAIN_RESET = 1'b0;
	localparam int CNT_WIDTH = 4;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam int OSC_CHANNELS = 3;
	localparam int OSC_HS = 0;
	localparam int OSC_INT = 1;
	localparam int OSC_SUB = 2;
	localparam logic [2:0] SYNC_RESET = 3'h0;
	localparam real CLK_PERIOD_NS = 20.0;
	localparam int INSTR_CPU_CLOCKS = 2;
	typedef enum logic [0:0] {ST_RUN, ST_WAIT_LOW} ccs_sw_state_t;
endpackage

// *** hw/ccs_osc_sync.sv ***
// three-stage sampler and change detector for the oscillator inputs
`timescale 1ns/10ps
module ccs_osc_sync (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ccs_pkg::OSC_CHANNELS-1:0] osc_in,
	output logic [ccs_pkg::OSC_CHANNELS-1:0] osc_level,
	output logic [ccs_pkg::OSC_CHANNELS-1:0] osc_change
);
	genvar g;
	generate
		for (g = 0; g < ccs_pkg::OSC_CHANNELS; g = g + 1) begin : g_ch
			logic [2:0] stg_r;
			logic lvl_r;
			logic chg_r;
			// first stage feeds only the second
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					stg_r <= ccs_pkg::SYNC_RESET;
				end else begin
					stg_r <= {stg_r[1:0], osc_in[g]};
				end
			end
			// accept a change only once stages two and three agree
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					lvl_r <= 1'b0;
					chg_r <= 1'b0;
				end else begin
					chg_r <= (stg_r[1] == stg_r[2]) && (stg_r[2] != lvl_r);
					if (stg_r[1] == stg_r[2]) begin
						lvl_r <= stg_r[2];
					end
				end
			end
			assign osc_level[g] = lvl_r;
			assign osc_change[g] = chg_r;
		end
	endgenerate
endmodule

// *** hw/ccs_clock_ctrl.sv ***
// processor clock control register with cpu clock source select and divider
`timescale 1ns/10ps
module ccs_clock_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wr_byte,
	input wire logic [7:0] wr_data,
	input wire logic wr_bit,
	input wire logic [2:0] wr_bit_idx,
	input wire logic wr_bit_val,
	output logic [7:0] rd_data,
	input wire logic main_clock_select,
	input wire logic main_osc_stop,
	input wire logic hs_osc_in,
	input wire logic int_osc_in,
	input wire logic sub_osc_in,
	output logic main_clock_status,
	output logic hs_osc_stop,
	output logic feedback_resistor_off,
	output logic cpu_clk,
	output logic cpu_tick,
	output logic instr_slot
);
	// stored bits; bit 5 and bit 3 are never stored
	logic [7:0] pcc_r;
	logic [7:0] pcc_nxt;
	logic [7:0] rd_data_r;

	// configuration the divider is running now
	logic app_sub_r;
	logic app_main_r;
	logic [2:0] app_div_r;

	ccs_pkg::ccs_sw_state_t sw_state_r;
	ccs_pkg::ccs_sw_state_t sw_state_nxt;

	logic [ccs_pkg::CNT_WIDTH-1:0] cnt_r;
	logic cpu_clk_r;
	logic cpu_tick_r;
	logic instr_phase_r;
	logic instr_slot_r;
	logic hs_stop_r;
	logic fb_off_r;
	logic mcs_r;

	logic [ccs_pkg::OSC_CHANNELS-1:0] osc_change;
	logic rise;
	logic on_int;
	logic src_evt;
	logic [ccs_pkg::CNT_WIDTH-1:0] lim;
	logic toggle;
	logic req_legal;
	logic req_differs;
	logic apply;

	// source edges after three-stage sampling
	// levels unused: only transitions drive the divider
	ccs_osc_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.osc_in({sub_osc_in, int_osc_in, hs_osc_in}),
		.osc_level(),
		.osc_change(osc_change)
	);

	// half period of the cpu clock, counted in source transitions, minus one
	// both source edges count, so a limit of zero passes the source through
	function automatic logic [ccs_pkg::CNT_WIDTH-1:0] div_limit(input logic sub, input logic [2:0] code);
		logic [2:0] eff;
		eff = sub ? ccs_pkg::SUB_DIV_CODE : code;
		case (eff)
			3'h0: div_limit = 4'h0;
			3'h1: div_limit = 4'h1;
			3'h2: div_limit = 4'h3;
			3'h3: div_limit = 4'h7;
			default: div_limit = 4'hf;
		endcase
	endfunction

	// divider codes above 100 are refused in both source modes
	// refused codes stay stored, so readback shows what software wrote
	function automatic logic cfg_legal(input logic [2:0] code);
		cfg_legal = (code <= ccs_pkg::DIV_MAX_CODE);
	endfunction

	// a write may never store bit 5 or bit 3
	function automatic logic bit_writable(input logic [2:0] idx);
		bit_writable = (idx != 3'(ccs_pkg::ON_SUB_BIT)) && (idx != 3'(ccs_pkg::ZERO_BIT));
	endfunction

	always_comb begin
		pcc_nxt = pcc_r;
		if (wr_byte) begin
			pcc_nxt = wr_data;
		end else if (wr_bit && bit_writable(wr_bit_idx)) begin
			pcc_nxt[wr_bit_idx] = wr_bit_val;
		end
		pcc_nxt[ccs_pkg::ZERO_BIT] = 1'b0;
		// status bit is built at readback, never stored
		pcc_nxt[ccs_pkg::ON_SUB_BIT] = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pcc_r <= ccs_pkg::PCC_RESET;
		end else begin
			pcc_r <= pcc_nxt;
		end
	end

	// status bit shows the applied source, not the request
	// readback lags the register by one cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_r <= ccs_pkg::PCC_RESET;
		end else begin
			rd_data_r <= {pcc_r[ccs_pkg::HS_STOP_BIT], pcc_r[ccs_pkg::FB_RES_OFF_BIT], app_sub_r,
				pcc_r[ccs_pkg::SUB_SEL_BIT], 1'b0, pcc_r[ccs_pkg::DIV_MSB:0]};
		end
	end

	// main clock picks high-speed or internal source
	// every source edge, rising or falling, advances the divider
	always_comb begin
		on_int = !app_sub_r && !app_main_r;
		if (app_sub_r) begin
			src_evt = osc_change[ccs_pkg::OSC_SUB];
		end else if (app_main_r) begin
			src_evt = osc_change[ccs_pkg::OSC_HS];
		end else begin
			src_evt = osc_change[ccs_pkg::OSC_INT];
		end
		lim = div_limit(app_sub_r, app_div_r);
		toggle = src_evt && (cnt_r == lim);
		// rising cpu clock edge at the next mclk edge
		rise = toggle && !cpu_clk_r;
	end

	always_comb begin
		req_legal = cfg_legal(pcc_r[ccs_pkg::DIV_MSB:0]);
		// div code ignored on subsystem, which always runs at half rate
		req_differs = (pcc_r[ccs_pkg::SUB_SEL_BIT] != app_sub_r)
			|| (main_clock_select != app_main_r)
			|| (!pcc_r[ccs_pkg::SUB_SEL_BIT] && (pcc_r[ccs_pkg::DIV_MSB:0] != app_div_r));
		// adopt only on the falling cpu clock edge
		apply = (sw_state_r == ccs_pkg::ST_WAIT_LOW) && toggle && cpu_clk_r;
	end

	// switch sequencing
	// limitation: a stopped old source leaves the switch waiting
	always_comb begin
		sw_state_nxt = sw_state_r;
		case (sw_state_r)
			ccs_pkg::ST_RUN: begin
				if (req_differs && req_legal) begin
					sw_state_nxt = ccs_pkg::ST_WAIT_LOW;
				end
			end
			ccs_pkg::ST_WAIT_LOW: begin
				// a request withdrawn while waiting simply cancels
				if (apply || !req_differs || !req_legal) begin
					sw_state_nxt = ccs_pkg::ST_RUN;
				end
			end
			default: begin
				sw_state_nxt = ccs_pkg::ST_RUN;
			end
		endcase
	end

	// wait state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sw_state_r <= ccs_pkg::ST_RUN;
		end else begin
			sw_state_r <= sw_state_nxt;
		end
	end

	// applied source and ratio
	// main select captured too, so status and source move together
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			app_sub_r <= ccs_pkg::APP_SUB_RESET;
			app_main_r <= ccs_pkg::APP_MAIN_RESET;
			app_div_r <= ccs_pkg::DIV_RESET;
		end else if (apply) begin
			app_sub_r <= pcc_r[ccs_pkg::SUB_SEL_BIT];
			app_main_r <= main_clock_select;
			app_div_r <= pcc_r[ccs_pkg::DIV_MSB:0];
		end
	end

	// restart the count so the new low phase is a full half period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= ccs_pkg::CNT_RESET;
		end else if (apply || toggle) begin
			cnt_r <= ccs_pkg::CNT_RESET;
		end else if (src_evt) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// cpu clock toggles every lim+1 source transitions
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_clk_r <= 1'b0;
		end else if (toggle) begin
			cpu_clk_r <= !cpu_clk_r;
		end
	end

	// tick on each rising cpu clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_tick_r <= 1'b0;
		end else begin
			cpu_tick_r <= rise;
		end
	end

	// instruction phase flips per rising edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			instr_phase_r <= 1'b0;
		end else if (rise) begin
			instr_phase_r <= !instr_phase_r;
		end
	end

	// one slot per two cpu clock rising edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			instr_slot_r <= 1'b0;
		end else begin
			instr_slot_r <= rise && instr_phase_r;
		end
	end

	// stop request; ignored on internal clock, main stop input acts there
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hs_stop_r <= 1'b0;
		end else if (on_int) begin
			hs_stop_r <= main_osc_stop;
		end else begin
			hs_stop_r <= pcc_r[ccs_pkg::HS_STOP_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fb_off_r <= 1'b0;
		end else begin
			fb_off_r <= pcc_r[ccs_pkg::FB_RES_OFF_BIT];
		end
	end

	// status follows the main source in use
	// lags the switch by one cycle, like the status bit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mcs_r <= 1'b0;
		end else begin
			mcs_r <= app_main_r;
		end
	end

	// every output is a flop wired straight out
	assign rd_data = rd_data_r;
	assign main_clock_status = mcs_r;
	assign hs_osc_stop = hs_stop_r;
	assign feedback_resistor_off = fb_off_r;
	assign cpu_clk = cpu_clk_r;
	assign cpu_tick = cpu_tick_r;
	assign instr_slot = instr_slot_r;
endmodule

// *** bench/ccs_clock_ctrl_asserts.sv ***
// checker for the cpu clock control block
`timescale 1ns/10ps
module ccs_clock_ctrl_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wr_byte,
	input wire logic [7:0] wr_data,
	input wire logic wr_bit,
	input wire logic [7:0] rd_data,
	input wire logic main_osc_stop,
	input wire logic main_clock_status,
	input wire logic hs_osc_stop,
	input wire logic feedback_resistor_off,
	input wire logic cpu_clk,
	input wire logic cpu_tick,
	input wire logic instr_slot
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// stable hs_osc_stop too: status lags the applied source by a cycle
	sequence s_quiet;
		(!wr_byte && !wr_bit && $stable(main_osc_stop) && $stable(main_clock_status)
			&& $stable(rd_data[5]) && $stable(hs_osc_stop))[*4];
	endsequence
	property p_rst_clear;
		$rose(rst_n) |-> rd_data == 8'h00;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("register not clear");
	property p_bit3;
		rd_data[3] == 1'b0;
	endproperty
	a_bit3: assert property (p_bit3) else $error("bit 3 set");
	property p_byte;
		wr_byte ##1 (!wr_byte && !wr_bit) |-> ##1 (rd_data & 8'hD7) == ($past(wr_data, 2) & 8'hD7);
	endproperty
	a_byte: assert property (p_byte) else $error("byte write lost");
	property p_fro;
		(!wr_byte && !wr_bit)[*3] |-> feedback_resistor_off == rd_data[6];
	endproperty
	a_fro: assert property (p_fro) else $error("resistor select wrong");
	property p_hs_run;
		s_quiet ##0 (main_clock_status || rd_data[5]) |-> hs_osc_stop == rd_data[7];
	endproperty
	a_hs_run: assert property (p_hs_run) else $error("stop bit ignored");
	property p_hs_int;
		s_quiet ##0 (!main_clock_status && !rd_data[5]) |-> hs_osc_stop == main_osc_stop;
	endproperty
	a_hs_int: assert property (p_hs_int) else $error("stop bit acted on internal");
	property p_tick;
		cpu_tick == $rose(cpu_clk);
	endproperty
	a_tick: assert property (p_tick) else $error("tick not on rising cpu clock");
	property p_slot;
		instr_slot |-> cpu_tick;
	endproperty
	a_slot: assert property (p_slot) else $error("slot off a tick");
endmodule

// *** bench/testbench.sv ***
// testbench for the cpu clock control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic mclk = 0, rst_n = 0, wr_byte = 0, wr_bit = 0, wr_bit_val = 0, main_clock_select = 0, main_osc_stop = 0;
	logic hs_osc_in = 0, int_osc_in = 0, sub_osc_in = 0;
	logic [7:0] wr_data = 8'h00;
	logic [2:0] wr_bit_idx = 3'h0;
	logic [7:0] rd_data;
	logic main_clock_status, hs_osc_stop, feedback_resistor_off, cpu_clk, cpu_tick, instr_slot;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	ccs_clock_ctrl ccs_clock_ctrl_i (.mclk(mclk), .rst_n(rst_n), .wr_byte(wr_byte), .wr_data(wr_data), .wr_bit(wr_bit),
		.wr_bit_idx(wr_bit_idx), .wr_bit_val(wr_bit_val), .rd_data(rd_data), .main_clock_select(main_clock_select),
		.main_osc_stop(main_osc_stop), .hs_osc_in(hs_osc_in), .int_osc_in(int_osc_in), .sub_osc_in(sub_osc_in),
		.main_clock_status(main_clock_status), .hs_osc_stop(hs_osc_stop), .feedback_resistor_off(feedback_resistor_off),
		.cpu_clk(cpu_clk), .cpu_tick(cpu_tick), .instr_slot(instr_slot));
	always #10 mclk = ~mclk;
	// periods 10, 14, 18 mclk, all above the sampler limit
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc % 5 == 0) hs_osc_in <= ~hs_osc_in;
		if (cyc % 7 == 0) int_osc_in <= ~int_osc_in;
		if (cyc % 9 == 0) sub_osc_in <= ~sub_osc_in;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input logic [7:0] d);
		@(posedge mclk);
		wr_byte <= 1'b1;
		wr_data <= d;
		@(posedge mclk);
		wr_byte <= 1'b0;
	endtask
	task wb(input logic [2:0] i, input logic v);
		@(posedge mclk);
		wr_bit <= 1'b1;
		wr_bit_idx <= i;
		wr_bit_val <= v;
		@(posedge mclk);
		wr_bit <= 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	// bounded wait, a stuck source shows as a wrong period
	task cnt(input logic slot, output int k);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while ((slot ? instr_slot : cpu_tick) !== 1'b1 && k < 2000);
	endtask
	task meas(input int p);
		int k;
		repeat (4) cnt(1'b0, k);
		`CHK("cpu period", p, k)
		`CHK("cpu clk", 1'b1, cpu_clk)
		cnt(1'b1, k);
		cnt(1'b1, k);
		`CHK("slot period", 2 * p, k)
	endtask
	task t_reset;
		`CHK("rd", 8'h00, rd_data)
		`CHK("status", 1'b0, main_clock_status)
		meas(14);
	endtask
	task t_main_div;
		@(posedge mclk);
		main_clock_select <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			wr(8'h40 | 8'(c));
			meas(10 << c);
			`CHK("rd", 8'h40 | 8'(c), rd_data)
		end
		`CHK("status", 1'b1, main_clock_status)
		`CHK("fro", 1'b1, feedback_resistor_off)
		wb(3'h7, 1'b1);
		`CHK("hs stop", 1'b1, hs_osc_stop)
		wb(3'h7, 1'b0);
	endtask
	task t_sub;
		wr(8'h10);
		meas(36);
		`CHK("rd", 8'h30, rd_data)
		`CHK("fro", 1'b0, feedback_resistor_off)
		wb(3'h7, 1'b1);
		`CHK("hs stop", 1'b1, hs_osc_stop)
		wr(8'h14);
		meas(36);
		wb(3'h5, 1'b0);
		wb(3'h3, 1'b0);
		`CHK("rd", 8'h34, rd_data)
	endtask
	// bit strobe in the byte-write cycle must lose
	task t_both;
		@(posedge mclk);
		wr_byte <= 1'b1;
		wr_data <= 8'h40;
		wr_bit <= 1'b1;
		wr_bit_idx <= 3'h7;
		wr_bit_val <= 1'b1;
		@(posedge mclk);
		wr_byte <= 1'b0;
		wr_bit <= 1'b0;
		meas(10);
		`CHK("rd", 8'h40, rd_data)
	endtask
	task t_internal;
		@(posedge mclk);
		main_clock_select <= 1'b0;
		// internal: code 1 divides by 2
		wr(8'h41);
		meas(28);
		`CHK("status", 1'b0, main_clock_status)
		wb(3'h7, 1'b1);
		`CHK("hs stop", 1'b0, hs_osc_stop)
		@(posedge mclk);
		main_osc_stop <= 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("hs stop", 1'b1, hs_osc_stop)
	endtask
	// reset in mid-run clears everything set before
	task t_rst_mid;
		@(posedge mclk);
		rst_n <= 1'b0;
		main_osc_stop <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("rd", 8'h00, rd_data)
		`CHK("hs stop", 1'b0, hs_osc_stop)
		`CHK("fro", 1'b0, feedback_resistor_off)
		`CHK("status", 1'b0, main_clock_status)
		meas(14);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(negedge mclk);
		t_reset();
		t_main_div();
		t_sub();
		t_both();
		t_internal();
		t_rst_mid();
		give_verdict();
	end
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_chk ccs_clock_ctrl_chk_i (.mclk(mclk), .rst_n(rst_n), .wr_byte(wr_byte),
	.wr_data(wr_data), .wr_bit(wr_bit), .rd_data(rd_data), .main_osc_stop(main_osc_stop),
	.main_clock_status(main_clock_status), .hs_osc_stop(hs_osc_stop), .feedback_resistor_off(feedback_resistor_off),
	.cpu_clk(cpu_clk), .cpu_tick(cpu_tick), .instr_slot(instr_slot));
